// [common/dasf_pkg.sv]
// Purpose: Constants for the accumulator status flag block.
// Assumes: AXI4-Lite register access, 32-bit data, byte addresses.
// Notes:   One copy of every offset, status and control bit position, and the level and irq reset values.
package dasf_pkg;
	localparam logic [3:0]  OFF_STATUS_WORD = 4'h0;
	localparam logic [3:0]  OFF_CONTROL     = 4'h4;
	localparam logic [3:0]  OFF_IRQ_STATUS  = 4'h8;
	localparam logic [3:0]  OFF_IRQ_MASK    = 4'hC;
	localparam int          BIT_OVF_A       = 15;
	localparam int          BIT_OVF_B       = 14;
	localparam int          BIT_SAT_A       = 13;
	localparam int          BIT_SAT_B       = 12;
	localparam int          BIT_OVF_AB      = 11;
	localparam int          BIT_SAT_AB      = 10;
	localparam int          BIT_IPL_LO      = 5;
	localparam int          BIT_NEST_DIS    = 0;
	localparam logic [2:0]  IPL_RESET       = 3'h0;
	localparam logic [2:0]  IPL_USER_OFF    = 3'h7;
	localparam logic [1:0]  RESP_OKAY       = 2'h0;
	localparam logic [1:0]  RESP_SLVERR     = 2'h2;
	localparam logic [3:0]  IRQ_RESET       = 4'h0;
	// Interrupt bit order: sat A, sat B, ovf A, ovf B
	localparam int          IRQ_BITS        = 4;
endpackage

// [verilog/dasf_status_flags.sv]
// Purpose: Accumulator overflow and sticky saturation flags, priority level
//          field, and the CPU status word seen over AXI4-Lite.
// Assumes: Saturation and overflow indications are synchronous to aclk.
// Notes:   Writes to the status word only clear sticky bits or load level.
//
// The AXI4-Lite register port and the address map were decided locally.
`timescale 1ns/10ps
module dasf_status_flags (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        acc_a_overflow,
	input  wire logic        acc_b_overflow,
	input  wire logic        acc_a_saturate,
	input  wire logic        acc_b_saturate,
	input  wire logic [3:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [3:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic [2:0]       interrupt_priority_level,
	output logic             user_irq_disabled,
	output logic             irq
);
	logic        acc_a_overflow_flag;
	logic        acc_b_overflow_flag;
	logic        acc_a_sticky_saturation;
	logic        acc_b_sticky_saturation;
	logic        either_acc_overflow_flag;
	logic        interrupt_nesting_disable;
	logic [3:0]  irq_status;
	logic [3:0]  irq_mask;
	logic        aw_held;
	logic        w_held;
	logic [3:0]  aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;

	logic        next_ovf_a;
	logic        next_ovf_b;
	logic        next_sat_a;
	logic        next_sat_b;
	logic        next_ovf_ab;
	logic        next_nest_dis;
	logic [2:0]  next_ipl;
	logic        next_user_off;
	logic [3:0]  next_irq_status;
	logic [3:0]  next_irq_mask;
	logic        next_irq;
	logic        next_aw_held;
	logic        next_w_held;
	logic [3:0]  next_aw_addr;
	logic [31:0] next_w_data;
	logic [3:0]  next_w_strb;
	logic        next_awready;
	logic        next_wready;
	logic        next_bvalid;
	logic [1:0]  next_bresp;
	logic        next_arready;
	logic        next_rvalid;
	logic [31:0] next_rdata;
	logic [1:0]  next_rresp;

	logic        wr_fire;
	logic [15:0] status_word;
	logic        sat_ab;
	logic [3:0]  irq_events;

	assign sat_ab = acc_a_sticky_saturation | acc_b_sticky_saturation;

	always_comb begin
		status_word = 16'h0000;
		status_word[dasf_pkg::BIT_OVF_A]  = acc_a_overflow_flag;
		status_word[dasf_pkg::BIT_OVF_B]  = acc_b_overflow_flag;
		status_word[dasf_pkg::BIT_SAT_A]  = acc_a_sticky_saturation;
		status_word[dasf_pkg::BIT_SAT_B]  = acc_b_sticky_saturation;
		status_word[dasf_pkg::BIT_OVF_AB] = either_acc_overflow_flag;
		status_word[dasf_pkg::BIT_SAT_AB] = sat_ab;
		status_word[dasf_pkg::BIT_IPL_LO +: 3] = interrupt_priority_level;
	end

	// Write executes once both address and data are held, response idle
	assign wr_fire = aw_held && w_held && !s_axi_bvalid;
	assign irq_events = {acc_b_overflow, acc_a_overflow,
		acc_b_saturate, acc_a_saturate};

	always_comb begin
		logic clr_a;
		logic clr_b;
		logic [15:0] wd;
		clr_a = 1'b0;
		clr_b = 1'b0;
		wd = w_data[15:0];
		next_aw_held  = aw_held;
		next_w_held   = w_held;
		next_aw_addr  = aw_addr;
		next_w_data   = w_data;
		next_w_strb   = w_strb;
		next_bvalid   = s_axi_bvalid;
		next_bresp    = s_axi_bresp;
		next_nest_dis = interrupt_nesting_disable;
		next_ipl      = interrupt_priority_level;
		next_irq_mask = irq_mask;
		next_irq_status = irq_status;
		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_held = 1'b1;
			next_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_held = 1'b1;
			next_w_data = s_axi_wdata;
			next_w_strb = s_axi_wstrb;
		end
		if (s_axi_bvalid && s_axi_bready) begin
			next_bvalid = 1'b0;
		end
		if (wr_fire) begin
			next_aw_held = 1'b0;
			next_w_held  = 1'b0;
			next_bvalid  = 1'b1;
			next_bresp   = dasf_pkg::RESP_OKAY;
			case (aw_addr)
				dasf_pkg::OFF_STATUS_WORD: begin
					if (w_strb[1]) begin
						clr_a = !wd[dasf_pkg::BIT_SAT_A];
						clr_b = !wd[dasf_pkg::BIT_SAT_B];
						if (!wd[dasf_pkg::BIT_SAT_AB]) begin
							clr_a = 1'b1;
							clr_b = 1'b1;
						end
					end
					if (w_strb[0] && !interrupt_nesting_disable) begin
						next_ipl = wd[dasf_pkg::BIT_IPL_LO +: 3];
					end
				end
				dasf_pkg::OFF_CONTROL: begin
					if (w_strb[0]) begin
						next_nest_dis = wd[dasf_pkg::BIT_NEST_DIS];
					end
				end
				dasf_pkg::OFF_IRQ_STATUS: begin
					if (w_strb[0]) begin
						next_irq_status = irq_status & ~wd[3:0];
					end
				end
				dasf_pkg::OFF_IRQ_MASK: begin
					if (w_strb[0]) begin
						next_irq_mask = wd[3:0];
					end
				end
				default: begin
					next_bresp = dasf_pkg::RESP_SLVERR;
				end
			endcase
		end
		// Set beats clear in the same cycle
		next_irq_status = next_irq_status | irq_events;
		next_awready = !next_aw_held && !next_bvalid;
		next_wready  = !next_w_held && !next_bvalid;
		next_ovf_a = acc_a_overflow;
		next_ovf_b = acc_b_overflow;
		next_ovf_ab = acc_a_overflow | acc_b_overflow;
		// Sticky A, saturation wins over clear
		next_sat_a = (acc_a_sticky_saturation && !clr_a) || acc_a_saturate;
		// Sticky B, saturation wins over clear
		next_sat_b = (acc_b_sticky_saturation && !clr_b) || acc_b_saturate;
		next_user_off = (next_ipl == dasf_pkg::IPL_USER_OFF);
		next_irq = |(next_irq_status & next_irq_mask);
	end

	always_comb begin
		// Ready whenever no read answer waits; reset loads arready low, so ready comes one cycle after reset
		next_arready = !s_axi_rvalid;
		next_rvalid  = s_axi_rvalid;
		next_rdata   = s_axi_rdata;
		next_rresp   = s_axi_rresp;
		if (s_axi_rvalid && s_axi_rready) begin
			next_rvalid  = 1'b0;
			next_arready = 1'b1;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			next_arready = 1'b0;
			next_rvalid  = 1'b1;
			next_rresp   = dasf_pkg::RESP_OKAY;
			next_rdata   = 32'h0000_0000;
			case (s_axi_araddr)
				dasf_pkg::OFF_STATUS_WORD: next_rdata[15:0] = status_word;
				dasf_pkg::OFF_CONTROL:
					next_rdata[dasf_pkg::BIT_NEST_DIS] =
						interrupt_nesting_disable;
				dasf_pkg::OFF_IRQ_STATUS: next_rdata[3:0] = irq_status;
				dasf_pkg::OFF_IRQ_MASK:   next_rdata[3:0] = irq_mask;
				default: next_rresp = dasf_pkg::RESP_SLVERR;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			acc_a_overflow_flag       <= 1'b0;
			acc_b_overflow_flag       <= 1'b0;
			acc_a_sticky_saturation   <= 1'b0;
			acc_b_sticky_saturation   <= 1'b0;
			either_acc_overflow_flag  <= 1'b0;
			interrupt_nesting_disable <= 1'b0;
			interrupt_priority_level  <= dasf_pkg::IPL_RESET;
			user_irq_disabled         <= 1'b0;
			irq_status                <= dasf_pkg::IRQ_RESET;
			irq_mask                  <= dasf_pkg::IRQ_RESET;
			irq                       <= 1'b0;
			aw_held                   <= 1'b0;
			w_held                    <= 1'b0;
			aw_addr                   <= 4'h0;
			w_data                    <= 32'h0000_0000;
			w_strb                    <= 4'h0;
			s_axi_awready             <= 1'b0;
			s_axi_wready              <= 1'b0;
			s_axi_bvalid              <= 1'b0;
			s_axi_bresp               <= dasf_pkg::RESP_OKAY;
			s_axi_arready             <= 1'b0;
			s_axi_rvalid              <= 1'b0;
			s_axi_rdata               <= 32'h0000_0000;
			s_axi_rresp               <= dasf_pkg::RESP_OKAY;
		end else begin
			acc_a_overflow_flag       <= next_ovf_a;
			acc_b_overflow_flag       <= next_ovf_b;
			acc_a_sticky_saturation   <= next_sat_a;
			acc_b_sticky_saturation   <= next_sat_b;
			either_acc_overflow_flag  <= next_ovf_ab;
			interrupt_nesting_disable <= next_nest_dis;
			interrupt_priority_level  <= next_ipl;
			user_irq_disabled         <= next_user_off;
			irq_status                <= next_irq_status;
			irq_mask                  <= next_irq_mask;
			irq                       <= next_irq;
			aw_held                   <= next_aw_held;
			w_held                    <= next_w_held;
			aw_addr                   <= next_aw_addr;
			w_data                    <= next_w_data;
			w_strb                    <= next_w_strb;
			s_axi_awready             <= next_awready;
			s_axi_wready              <= next_wready;
			s_axi_bvalid              <= next_bvalid;
			s_axi_bresp               <= next_bresp;
			s_axi_arready             <= next_arready;
			s_axi_rvalid              <= next_rvalid;
			s_axi_rdata               <= next_rdata;
			s_axi_rresp               <= next_rresp;
		end
	end

	ovf_a_track_a: assert property (
		@(posedge aclk) disable iff (!aresetn)
		acc_a_overflow_flag == $past(acc_a_overflow))
		else $error("overflow A flag mismatch");
	ovf_b_track_a: assert property (
		@(posedge aclk) disable iff (!aresetn)
		acc_b_overflow_flag == $past(acc_b_overflow))
		else $error("overflow B flag mismatch");
	sat_a_set_a: assert property (
		@(posedge aclk) disable iff (!aresetn)
		acc_a_saturate |=> acc_a_sticky_saturation)
		else $error("sticky A not set");
	sat_b_hold_a: assert property (
		@(posedge aclk) disable iff (!aresetn)
		acc_b_sticky_saturation && !wr_fire |=> acc_b_sticky_saturation)
		else $error("sticky B lost");
	ovf_ab_or_a: assert property (
		@(posedge aclk) disable iff (!aresetn)
		either_acc_overflow_flag == $past(acc_a_overflow | acc_b_overflow))
		else $error("combined overflow wrong");
	sat_ab_clr_a: assert property (
		@(posedge aclk) disable iff (!aresetn)
		wr_fire && aw_addr == dasf_pkg::OFF_STATUS_WORD && w_strb[1] &&
		!w_data[dasf_pkg::BIT_SAT_AB] && !acc_a_saturate && !acc_b_saturate
		|=> !sat_ab)
		else $error("combined clear missed");
	ipl_lock_a: assert property (
		@(posedge aclk) disable iff (!aresetn)
		interrupt_nesting_disable |=> $stable(interrupt_priority_level))
		else $error("level changed while locked");
	ipl_seven_a: assert property (
		@(posedge aclk) disable iff (!aresetn)
		##1 user_irq_disabled ==
		($past(next_ipl) == dasf_pkg::IPL_USER_OFF))
		else $error("level seven flag wrong");
	sat_no_set_a: assert property (
		@(posedge aclk) disable iff (!aresetn)
		!acc_a_sticky_saturation && !acc_a_saturate
		|=> !acc_a_sticky_saturation)
		else $error("sticky A set without saturation");
endmodule

// [dv/dasf_status_flags_tb.sv]
// Purpose: Self-checking bench for the accumulator status flag block.
// Assumes: One 40 MHz clock; AXI4-Lite master lives in the bench tasks.
// Notes:   Status word writes carry the level in lvl, as lane 0 loads it; the locked-level check writes level 3.
`timescale 1ns/10ps
module dasf_status_flags_tb;
	localparam logic [3:0] SW = dasf_pkg::OFF_STATUS_WORD;
	localparam logic [3:0] CT = dasf_pkg::OFF_CONTROL;
	localparam logic [3:0] IS = dasf_pkg::OFF_IRQ_STATUS;
	localparam logic [3:0] IM = dasf_pkg::OFF_IRQ_MASK;
	logic        aclk, aresetn, acc_a_overflow, acc_b_overflow;
	logic        acc_a_saturate, acc_b_saturate;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, user_off, irq;
	logic [3:0]  awaddr, araddr, wstrb;
	logic [31:0] wdata, rdata;
	logic [1:0]  bresp, rresp;
	logic [2:0]  level, lvl;
	int          num_errors, cmp_count;
	logic [1:0]  exp_resp;

	dasf_status_flags dut_u (.aclk(aclk), .aresetn(aresetn),
		.acc_a_overflow(acc_a_overflow), .acc_b_overflow(acc_b_overflow),
		.acc_a_saturate(acc_a_saturate), .acc_b_saturate(acc_b_saturate),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.interrupt_priority_level(level), .user_irq_disabled(user_off),
		.irq(irq));

	always #12.5 aclk = ~aclk;

	task automatic print_verdict();
		$display("comparisons %0d, mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string m);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	task automatic fail_wait();
		num_errors++;
		$display("wrong value at %0t: handshake timed out", $time);
		print_verdict();
	endtask

	// Status word image with the level field the bench believes is loaded
	function automatic logic [31:0] stw(input logic [15:0] f);
		return {16'h0, f} | {24'h0, lvl, 5'h0};
	endfunction

	task automatic wr(input logic [3:0] a, input logic [31:0] d,
		input logic [3:0] s);
		int n;
		bit got;
		n = 0;
		got = 0;
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
			got = bvalid;
		end while (!got && n < 50);
		if (!got)
			fail_wait();
		chk({30'h0, bresp}, {30'h0, exp_resp}, "bresp");
	endtask

	task automatic rdchk(input logic [3:0] a, input logic [31:0] exp,
		input string m);
		int n;
		bit got;
		n = 0;
		got = 0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (arvalid && arready)
				arvalid <= 1'b0;
			got = rvalid;
		end while (!got && n < 50);
		if (!got)
			fail_wait();
		chk({30'h0, rresp}, {30'h0, exp_resp}, "rresp");
		chk(rdata, exp, m);
	endtask

	task automatic pulse(input logic a, input logic b);
		acc_a_saturate <= a;
		acc_b_saturate <= b;
		@(posedge aclk);
		acc_a_saturate <= 1'b0;
		acc_b_saturate <= 1'b0;
		repeat (3) @(posedge aclk);
	endtask

	task automatic t_reset();
		rdchk(SW, 32'h0, "status reset");
		rdchk(CT, 32'h0, "control reset");
		rdchk(IS, 32'h0, "irq status reset");
		rdchk(IM, 32'h0, "irq mask reset");
		chk({29'h0, level}, {29'h0, dasf_pkg::IPL_RESET},
			"level reset");
		chk({31'h0, irq}, 32'h0, "irq reset");
		$display("test reset done");
	endtask

	task automatic t_overflow();
		acc_a_overflow <= 1'b1;
		repeat (3) @(posedge aclk);
		rdchk(SW, stw(16'h8800), "ovf a");
		// Ones on 14 and zero on 15 must both be ignored
		wr(SW, stw(16'h4000), 4'h3);
		rdchk(SW, stw(16'h8800), "ovf read only");
		acc_a_overflow <= 1'b0;
		acc_b_overflow <= 1'b1;
		repeat (3) @(posedge aclk);
		rdchk(SW, stw(16'h4800), "ovf b");
		acc_b_overflow <= 1'b0;
		repeat (3) @(posedge aclk);
		rdchk(SW, stw(16'h0000), "ovf none");
		// Both overflow events latched in interrupt status bits 2 and 3
		rdchk(IS, 32'hC, "ovf events");
		$display("test overflow done");
	endtask

	task automatic t_sticky();
		pulse(1'b1, 1'b0);
		rdchk(SW, stw(16'h2400), "sat a held");
		wr(SW, stw(16'h3400), 4'h3);
		rdchk(SW, stw(16'h2400), "one never sets");
		wr(SW, stw(16'h1400), 4'h3);
		rdchk(SW, stw(16'h0000), "clear a");
		pulse(1'b0, 1'b1);
		rdchk(SW, stw(16'h1400), "sat b held");
		pulse(1'b1, 1'b0);
		rdchk(SW, stw(16'h3400), "sat both");
		wr(SW, stw(16'h3000), 4'h3);
		rdchk(SW, stw(16'h0000), "combined clear");
		$display("test sticky done");
	endtask

	task automatic t_level();
		for (int i = 0; i < 8; i++) begin
			lvl = i[2:0];
			wr(SW, stw(16'h3400), 4'h3);
			rdchk(SW, stw(16'h0000), "level read");
			chk({29'h0, level}, {29'h0, lvl}, "level out");
			chk({31'h0, user_off}, {31'h0, lvl == dasf_pkg::IPL_USER_OFF},
				"user irq off");
		end
		wr(CT, 32'h1, 4'h1);
		rdchk(CT, 32'h1, "nesting disable");
		wr(SW, 32'h3460, 4'h3);
		rdchk(SW, stw(16'h0000), "level locked");
		wr(CT, 32'h0, 4'h1);
		lvl = 3'h3;
		wr(SW, stw(16'h3400), 4'h3);
		rdchk(SW, stw(16'h0000), "level free");
		chk({31'h0, user_off}, 32'h0, "user irq on");
		$display("test level done");
	endtask

	task automatic t_irq();
		wr(IS, 32'hF, 4'h1);
		rdchk(IS, 32'h0, "irq status clear");
		wr(IM, 32'h1, 4'h1);
		pulse(1'b0, 1'b1);
		chk({31'h0, irq}, 32'h0, "masked event");
		pulse(1'b1, 1'b0);
		chk({31'h0, irq}, 32'h1, "irq raised");
		rdchk(IS, 32'h3, "irq status");
		wr(IM, 32'h0, 4'h1);
		repeat (3) @(posedge aclk);
		chk({31'h0, irq}, 32'h0, "mask off");
		wr(IM, 32'h1, 4'h1);
		repeat (3) @(posedge aclk);
		chk({31'h0, irq}, 32'h1, "mask on");
		wr(IS, 32'h1, 4'h1);
		repeat (3) @(posedge aclk);
		chk({31'h0, irq}, 32'h0, "irq cleared");
		rdchk(IS, 32'h2, "one bit cleared");
		wr(SW, stw(16'h0000), 4'h3);
		$display("test irq done");
	endtask

	task automatic t_unmapped();
		exp_resp = dasf_pkg::RESP_SLVERR;
		// Would load level seven if wrongly decoded as the status word
		wr(4'h2, 32'h0000_00E0, 4'h1);
		rdchk(4'h2, 32'h0, "unmapped read");
		exp_resp = dasf_pkg::RESP_OKAY;
		rdchk(SW, stw(16'h0000), "unmapped no effect");
		$display("test unmapped done");
	endtask

	initial begin
		aclk = 1'b0;
		aresetn = 1'b0;
		{acc_a_overflow, acc_b_overflow, acc_a_saturate, acc_b_saturate} = '0;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		awaddr = '0;
		araddr = '0;
		wstrb = '0;
		wdata = '0;
		lvl = dasf_pkg::IPL_RESET;
		exp_resp = dasf_pkg::RESP_OKAY;
		num_errors = 0;
		cmp_count = 0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_reset();
		t_overflow();
		t_sticky();
		t_level();
		t_irq();
		t_unmapped();
		print_verdict();
	end
endmodule
